// [audio_pin_control_sequencer.v]
// audio_pin_control_sequencer.v: power-down, back-end error, headphone select and mute sequencing
// assumes: registers are written through a simple internal register port (I2C slave decoded outside)
`timescale 1ns/10ps
`include "audio_pin_seq_defs.vh"

module audio_pin_control_sequencer #(
  parameter integer NUM_CH        = 8,
  parameter integer BKND_WAIT     = `BKND_WAIT_CYCLES,
  parameter integer REINIT_LEN    = `REINIT_CYCLES,
  parameter integer RATE_DET_LEN  = `RATE_DETECT_CYCLES
) (
  input  wire                clk_i,
  input  wire                resetn_i,
  input  wire                power_down_n_i,
  input  wire                backend_fault_n_i,
  input  wire                headphone_speaker_select_i,
  input  wire                mute_n_i,
  input  wire                reg_wr_i,
  input  wire                reg_rd_i,
  input  wire [7:0]          reg_addr_i,
  input  wire [31:0]         reg_wdata_i,
  input  wire                serial_audio_valid_i,
  input  wire [NUM_CH-1:0]   channel_mute_i,
  input  wire                am_mute_i,
  input  wire                bank_switch_mute_i,
  input  wire                automute_i,
  input  wire [NUM_CH-1:0]   pwm_data_i,
  input  wire [7:0]          headphone_config_i,
  output reg  [31:0]         reg_rdata_o,
  output reg                 serial_audio_accept_o,
  output reg                 pll_enable_o,
  output reg                 osc_enable_o,
  output reg                 valid_o,
  output reg  [NUM_CH-1:0]   pwm_p_o,
  output reg  [NUM_CH-1:0]   pwm_m_o,
  output reg  [1:0]          headphone_pwm_p_o,
  output reg  [1:0]          headphone_pwm_m_o,
  output reg                 supply_volume_ctrl_out_o,
  output reg                 sda_oe_n_o,
  output reg  [7:0]          volume_o,
  output reg  [7:0]          ch12_config_o,
  output reg                 fault_active_o
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [5:0] ST_PDN    = 6'h01;
  localparam [5:0] ST_RATE   = 6'h02;
  localparam [5:0] ST_RUN    = 6'h04;
  localparam [5:0] ST_BKWAIT = 6'h08;
  localparam [5:0] ST_REINIT = 6'h10;
  localparam [5:0] ST_SWAP   = 6'h20;

  localparam [7:0] VOL_MAX = `RAMP_STEPS;
  localparam [2:0] BK_MIN  = `BKND_LOW_MIN_CYCLES;

  // ************************************************************
  // power-down: asynchronous entry, released through a synchroniser
  // ************************************************************
  wire pdn_rst_n;
  assign pdn_rst_n = resetn_i & power_down_n_i;

  reg [2:0] pdn_sync;
  always @(posedge clk_i or negedge pdn_rst_n) begin
    if (!pdn_rst_n) begin
      pdn_sync <= 3'h0;
    end else begin
      pdn_sync <= {pdn_sync[1:0], 1'b1};
    end
  end
  wire pdn_run;
  assign pdn_run = pdn_sync[2];

  // ************************************************************
  // pin synchronisers: three flops, change counts when last two agree
  // ************************************************************
  reg [2:0] bk_sync;
  reg [2:0] hp_sync;
  reg [2:0] mu_sync;
  reg       bk_lvl;
  reg       hp_lvl;
  reg       mu_lvl;
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bk_sync <= 3'h7;
      hp_sync <= 3'h7;
      mu_sync <= 3'h7;
      bk_lvl  <= 1'b1;
      hp_lvl  <= 1'b1;
      mu_lvl  <= 1'b1;
    end else begin
      bk_sync <= {bk_sync[1:0], backend_fault_n_i};
      hp_sync <= {hp_sync[1:0], headphone_speaker_select_i};
      mu_sync <= {mu_sync[1:0], mute_n_i};
      if (bk_sync[2] == bk_sync[1]) begin
        bk_lvl <= bk_sync[2];
      end
      if (hp_sync[2] == hp_sync[1]) begin
        hp_lvl <= hp_sync[2];
      end
      if (mu_sync[2] == mu_sync[1]) begin
        mu_lvl <= mu_sync[2];
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  reg [7:0]  lineout_ch5_config;
  reg [7:0]  lineout_ch6_config;
  reg [31:0] output_mixer_config;
  reg [31:0] general_control;
  wire       six_ch;
  wire       master_mute_n;
  assign six_ch        = general_control[`GC_CHANNEL_COUNT_BIT];
  assign master_mute_n = general_control[`GC_MASTER_MUTE_N_BIT];

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lineout_ch5_config  <= `RST_LINEOUT_CONFIG;
      lineout_ch6_config  <= `RST_LINEOUT_CONFIG;
      output_mixer_config <= `RST_OUTPUT_MIXER_CONFIG;
      general_control     <= `RST_GENERAL_CONTROL;
    end else if (reg_wr_i && pdn_run) begin
      case (reg_addr_i)
        `REG_LINEOUT_CH5_CONFIG:  lineout_ch5_config  <= reg_wdata_i[7:0];
        `REG_LINEOUT_CH6_CONFIG:  lineout_ch6_config  <= reg_wdata_i[7:0];
        `REG_OUTPUT_MIXER_CONFIG: output_mixer_config <= reg_wdata_i;
        `REG_GENERAL_CONTROL:     general_control     <= {28'h0000000, 1'b0, reg_wdata_i[2:0]};
        default: ;
      endcase
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i && pdn_run) begin
      case (reg_addr_i)
        `REG_LINEOUT_CH5_CONFIG:  reg_rdata_o <= {24'h000000, lineout_ch5_config};
        `REG_LINEOUT_CH6_CONFIG:  reg_rdata_o <= {24'h000000, lineout_ch6_config};
        `REG_OUTPUT_MIXER_CONFIG: reg_rdata_o <= output_mixer_config;
        `REG_GENERAL_CONTROL:     reg_rdata_o <= general_control;
        default:                  reg_rdata_o <= 32'h00000000;
      endcase
    end
  end

  // ************************************************************
  // back-end fault low-time counter on the synchronised level
  // ************************************************************
  reg [2:0] bk_cnt;
  reg       bk_event;
  always @(posedge clk_i or negedge pdn_rst_n) begin
    if (!pdn_rst_n) begin
      bk_cnt   <= 3'h0;
      bk_event <= 1'b0;
    end else if (bk_lvl) begin
      bk_cnt   <= 3'h0;
      bk_event <= 1'b0;
    end else if (bk_cnt != BK_MIN) begin
      bk_cnt   <= bk_cnt + 3'h1;
      bk_event <= (bk_cnt == BK_MIN - 3'h1);
    end else begin
      bk_event <= 1'b0;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  reg [5:0]  state;
  reg [31:0] timer;
  reg        hp_prev;
  wire       mute_req;
  assign mute_req = ~mu_lvl | ~master_mute_n | am_mute_i | bank_switch_mute_i | automute_i;

  always @(posedge clk_i or negedge pdn_rst_n) begin
    if (!pdn_rst_n) begin
      state   <= ST_PDN;
      timer   <= 32'h0;
      hp_prev <= 1'b1;
    end else begin
      hp_prev <= hp_lvl;
      case (state)
        ST_PDN: begin
          if (pdn_run) begin
            state <= ST_RATE;
          end
          timer <= 32'h0;
        end
        ST_RATE: begin
          timer <= timer + 32'h1;
          if (timer == RATE_DET_LEN - 1) begin
            state <= ST_RUN;
            timer <= 32'h0;
          end
        end
        ST_RUN: begin
          if (bk_event) begin
            state <= ST_BKWAIT;
            timer <= 32'h0;
          end else if (hp_lvl != hp_prev) begin
            state <= ST_SWAP;
          end
        end
        ST_BKWAIT: begin
          timer <= timer + 32'h1;
          if (timer == BKND_WAIT - 1) begin
            state <= ST_REINIT;
            timer <= 32'h0;
          end
        end
        ST_REINIT: begin
          timer <= timer + 32'h1;
          if (timer == REINIT_LEN - 1) begin
            state <= ST_RUN;
            timer <= 32'h0;
          end
        end
        ST_SWAP: begin
          if (volume_o == 8'h00) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_PDN;
      endcase
    end
  end

  // ************************************************************
  // volume ramp: mute sources override unmute, unmute ramps back up to VOL_MAX
  // ************************************************************
  wire ramp_down;
  assign ramp_down = mute_req | (state != ST_RUN);

  always @(posedge clk_i or negedge pdn_rst_n) begin
    if (!pdn_rst_n) begin
      volume_o <= 8'h00;
    end else if (ramp_down) begin
      if (volume_o != 8'h00) begin
        volume_o <= volume_o - 8'h01;
      end
    end else if (volume_o != VOL_MAX) begin
      volume_o <= volume_o + 8'h01;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  wire       headphone_speaker_select;
  wire       in_fault;
  wire       pwm_on;
  reg  [NUM_CH-1:0] spk_en;
  reg  [NUM_CH-1:0] fault_mask;
  integer i;
  integer j;
  assign headphone_speaker_select   = ~hp_lvl;
  assign in_fault = (state == ST_BKWAIT) | (state == ST_REINIT);
  assign pwm_on   = pdn_run & (state == ST_RUN || state == ST_SWAP) & (volume_o != 8'h00);

  always @* begin
    fault_mask = {NUM_CH{1'b1}};
    spk_en     = {NUM_CH{1'b1}};
    if (six_ch) begin
      fault_mask[4] = 1'b0;
      fault_mask[5] = 1'b0;
    end
    if (headphone_speaker_select) begin
      spk_en[0] = 1'b0;
      spk_en[1] = 1'b0;
    end
    for (i = 0; i < NUM_CH; i = i + 1) begin
      if (six_ch && (i == 4 || i == 5)) begin
        spk_en[i] = 1'b1;
      end
    end
  end

  always @(posedge clk_i or negedge pdn_rst_n) begin
    if (!pdn_rst_n) begin
      valid_o                  <= 1'b0;
      pwm_p_o                  <= {NUM_CH{1'b0}};
      pwm_m_o                  <= {NUM_CH{1'b0}};
      headphone_pwm_p_o        <= 2'h0;
      headphone_pwm_m_o        <= 2'h0;
      supply_volume_ctrl_out_o <= 1'b0;
      sda_oe_n_o               <= 1'b1;
      pll_enable_o             <= 1'b0;
      osc_enable_o             <= 1'b0;
      serial_audio_accept_o    <= 1'b0;
      ch12_config_o            <= 8'h00;
      fault_active_o           <= 1'b0;
    end else begin
      pll_enable_o          <= 1'b1;
      osc_enable_o          <= 1'b1;
      sda_oe_n_o            <= 1'b1;
      serial_audio_accept_o <= serial_audio_valid_i;
      fault_active_o        <= in_fault;
      valid_o               <= pdn_run & ((state == ST_RUN) | (state == ST_SWAP));
      ch12_config_o         <= headphone_speaker_select ? headphone_config_i : 8'h00;
      supply_volume_ctrl_out_o <= general_control[`GC_SUPPLY_VOLUME_CTRL_OUT_ENABLE_BIT] & pwm_on;
      for (j = 0; j < NUM_CH; j = j + 1) begin
        if (channel_mute_i[j]) begin
          pwm_p_o[j] <= 1'b0;
          pwm_m_o[j] <= 1'b0;
        end else if ((in_fault && fault_mask[j]) || !spk_en[j] || (!pwm_on && !(six_ch && (j == 4 || j == 5)))) begin
          pwm_p_o[j] <= 1'b0;
          pwm_m_o[j] <= 1'b0;
        end else begin
          pwm_p_o[j] <= pwm_data_i[j];
          pwm_m_o[j] <= ~pwm_data_i[j];
        end
      end
      if (headphone_speaker_select && pwm_on && !in_fault) begin
        headphone_pwm_p_o <= pwm_data_i[1:0];
        headphone_pwm_m_o <= ~pwm_data_i[1:0];
      end else begin
        headphone_pwm_p_o <= 2'h0;
        headphone_pwm_m_o <= 2'h0;
      end
    end
  end

endmodule // audio_pin_control_sequencer

// [audio_pin_control_sequencer_bench.sv]
// audio_pin_control_sequencer_bench.sv: self-checking bench for the pin sequencer
// assumes: checker and power stage model compiled first; fault and rate counts shortened
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module audio_pin_control_sequencer_bench;
  localparam integer BW = 50;
  localparam integer RL = 64;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  reg        clk_i, resetn_i, power_down_n_i, headphone_speaker_select_i, mute_n_i;
  reg        reg_wr_i, reg_rd_i, serial_audio_valid_i, fault_go;
  reg  [7:0] reg_addr_i, headphone_config_i, fault_len, lo;
  reg  [31:0] reg_wdata_i;
  reg  [2:0] msrc;
  reg  [7:0] chm;
  wire       backend_fault_n, serial_audio_accept_o, pll_enable_o, osc_enable_o, valid_o;
  wire       supply_volume_ctrl_out_o, sda_oe_n_o, fault_active_o;
  wire [7:0] pwm_data, pwm_p_o, pwm_m_o, volume_o, ch12_config_o;
  wire [1:0] headphone_pwm_p_o, headphone_pwm_m_o;
  wire [31:0] reg_rdata_o;
  row_t      rows [0:8];
  int        err_count = 0;
  int        checked = 0;
  int        n;
  audio_pin_control_sequencer #(.NUM_CH(8), .BKND_WAIT(BW), .REINIT_LEN(RL), .RATE_DET_LEN(8))
    i_audio_pin_control_sequencer (.clk_i, .resetn_i, .power_down_n_i, .backend_fault_n_i(backend_fault_n),
    .headphone_speaker_select_i, .mute_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
    .serial_audio_valid_i, .channel_mute_i(chm), .am_mute_i(msrc[0]), .bank_switch_mute_i(msrc[1]),
    .automute_i(msrc[2]), .pwm_data_i(pwm_data), .headphone_config_i, .reg_rdata_o, .serial_audio_accept_o,
    .pll_enable_o, .osc_enable_o, .valid_o, .pwm_p_o, .pwm_m_o, .headphone_pwm_p_o, .headphone_pwm_m_o,
    .supply_volume_ctrl_out_o, .sda_oe_n_o, .volume_o, .ch12_config_o, .fault_active_o);
  power_stage_model i_power_stage_model (.clk_i, .fault_go_i(fault_go), .fault_len_i(fault_len),
    .backend_fault_n_o(backend_fault_n), .pwm_data_o(pwm_data));
  // ****************
  // clock and tasks
  // ****************
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
    step(1);
  endtask
  task automatic rd(input [7:0] a);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    step(1);
  endtask
  task automatic vol_wait(input [7:0] v);
    for (int k = 0; k < 300 && volume_o !== v; k++) step(1);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    summarize;
  end
  // ****************
  // tests
  // ****************
  initial begin
    {resetn_i, power_down_n_i, mute_n_i, reg_wr_i, reg_rd_i, fault_go, msrc} = 0;
    {headphone_speaker_select_i, serial_audio_valid_i} = 2'b11;
    {reg_addr_i, reg_wdata_i, fault_len, chm} = 0;
    headphone_config_i = 8'h3c;
    rows = '{'{0, 8'h09, 0, 32'he0}, '{0, 8'h0a, 0, 32'he0}, '{0, 8'hd0, 0, 0}, '{0, 8'he0, 0, 0},
      '{1, 8'h09, 0, 0}, '{1, 8'h0a, 0, 0}, '{1, 8'hd0, 32'h40000000, 32'h40000000},
      '{1, 8'h33, 32'h1234, 0}, '{1, 8'he0, 32'hffffffff, 32'h7}};
    step(8);
    resetn_i = 1'b1;
    wr(8'he0, 32'h1);
    `CHK("accept", 1'b0, serial_audio_accept_o)
    step(5);
    power_down_n_i = 1'b1;
    step(40);
    `CHK("valid", 1'b1, valid_o)
    `CHK("clocks", 2'b11, {pll_enable_o, osc_enable_o})
    `CHK("volume", 8'h00, volume_o)
    rd(8'he0);
    `CHK("gc", 32'h0, reg_rdata_o)
    $display("test power-down done");
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      `CHK("rdata", rows[i].e, reg_rdata_o)
    end
    mute_n_i = 1'b1;
    vol_wait(8'hff);
    `CHK("volume", 8'hff, volume_o)
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      msrc = (k < 3) ? (3'b001 << k) : 3'b000;
      mute_n_i = (k != 3);
      if (k == 4) wr(8'he0, 32'h6);
      vol_wait(8'h00);
      `CHK("muted", 8'h00, volume_o)
      msrc = 3'b000;
      mute_n_i = 1'b1;
      if (k == 4) wr(8'he0, 32'h7);
      vol_wait(8'hff);
      `CHK("unmuted", 8'hff, volume_o)
    end
    chm = 8'h01;
    step(2);
    `CHK("ch mute", 2'b00, {pwm_p_o[0], pwm_m_o[0]})
    chm = 8'h00;
    $display("test mute sources done");
    wr(8'hd0, 32'h0);
    for (int s = 0; s < 2; s++) begin
      headphone_speaker_select_i = s;
      vol_wait(8'h00);
      `CHK("sel mute", 8'h00, volume_o)
      mute_n_i = 1'b0;
      step(6);
      mute_n_i = 1'b1;
      vol_wait(8'hff);
      `CHK("sel unmute", 8'hff, volume_o)
      `CHK("ch12", s ? 8'h00 : headphone_config_i, ch12_config_o)
    end
    $display("test select done");
    for (int m = 0; m < 2; m++) begin
      wr(8'he0, m ? 32'h7 : 32'h5);
      fault_len = 8'd4;
      fault_go = 1'b1;
      step(1);
      fault_go = 1'b0;
      step(20);
      `CHK("blip", 1'b0, fault_active_o)
      fault_len = 8'd12;
      fault_go = 1'b1;
      step(1);
      fault_go = 1'b0;
      for (n = 0; n < 30 && fault_active_o !== 1'b1; n++) step(1);
      `CHK("fault", 1'b1, fault_active_o)
      lo = 8'h00;
      for (n = 0; n < 400 && fault_active_o === 1'b1; n++) begin
        lo = lo | pwm_p_o[5:4];
        step(1);
      end
      `CHK("span", 1'b1, n >= BW && n <= BW + RL + 2)
      `CHK("lineout", m[0], lo != 8'h00)
      step(30);
      `CHK("resume", 1'b1, valid_o)
    end
    $display("test fault done");
    power_down_n_i = 1'b0;
    #1;
    `CHK("pdn clocks", 2'b00, {pll_enable_o, osc_enable_o})
    `CHK("pdn supply_volume_ctrl_out", 1'b0, supply_volume_ctrl_out_o)
    `CHK("pdn volume", 8'h00, volume_o)
    `CHK("pdn pwm", 8'h00, pwm_p_o)
    `CHK("pdn valid", 1'b0, valid_o)
    step(8);
    $display("test async power-down done");
    summarize;
  end
endmodule // audio_pin_control_sequencer_bench

// [audio_pin_control_sequencer_props.sv]
// audio_pin_control_sequencer_props.sv: port assertions for the pin sequencer
// assumes: bound to audio_pin_control_sequencer with NUM_CH of 8
`timescale 1ns/10ps
module audio_pin_seq_checker #(
  parameter integer NUM_CH       = 8,
  parameter integer BKND_WAIT    = 50,
  parameter integer REINIT_LEN   = 64,
  parameter integer RATE_DET_LEN = 8
) (
  input wire              clk_i,
  input wire              resetn_i,
  input wire              power_down_n_i,
  input wire              backend_fault_n_i,
  input wire              headphone_speaker_select_i,
  input wire              mute_n_i,
  input wire [7:0]        headphone_config_i,
  input wire              serial_audio_accept_o,
  input wire              pll_enable_o,
  input wire              osc_enable_o,
  input wire              valid_o,
  input wire [NUM_CH-1:0] pwm_p_o,
  input wire [NUM_CH-1:0] pwm_m_o,
  input wire [1:0]        headphone_pwm_p_o,
  input wire [1:0]        headphone_pwm_m_o,
  input wire              supply_volume_ctrl_out_o,
  input wire              sda_oe_n_o,
  input wire [7:0]        volume_o,
  input wire [7:0]        ch12_config_o,
  input wire              fault_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // cycles spent with the fault flag up
  int fcnt;
  always @(posedge clk_i or negedge resetn_i)
    if (!resetn_i) fcnt <= 0;
    else if (fault_active_o) fcnt <= fcnt + 1;
    else fcnt <= 0;
  sequence pdn_held; !power_down_n_i; endsequence
  sequence fault_held; power_down_n_i && $fell(backend_fault_n_i) ##1 (!backend_fault_n_i)[*7]; endsequence
  sequence fault_blip; $fell(backend_fault_n_i) ##1 (!backend_fault_n_i)[*3] ##1 backend_fault_n_i; endsequence
  a_pdn_outputs_low: assert property (pdn_held |-> !valid_o && pwm_p_o == 0 && pwm_m_o == 0)
    else $error("outputs active in power-down");
  a_pdn_supply_volume_ctrl_out_low: assert property (pdn_held |-> !supply_volume_ctrl_out_o && sda_oe_n_o)
    else $error("supply control or sda driven in power-down");
  a_pdn_clocks_off: assert property (pdn_held |-> !pll_enable_o && !osc_enable_o && volume_o == 0)
    else $error("clocks or volume alive in power-down");
  a_pdn_no_audio: assert property (pdn_held |-> !serial_audio_accept_o)
    else $error("audio accepted in power-down");
  a_rate_first: assert property ($rose(power_down_n_i) |-> (!valid_o)[*8])
    else $error("valid before rate detection");
  a_fault_enters: assert property (fault_held |-> ##[1:4] fault_active_o)
    else $error("held fault not taken");
  a_blip_ignored: assert property (!fault_active_o ##0 fault_blip |-> (!fault_active_o)[*6])
    else $error("short fault taken");
  a_fault_span: assert property ($fell(fault_active_o) && power_down_n_i |-> fcnt >= BKND_WAIT)
    else $error("fault recovery too short");
  a_fault_bounded: assert property (fcnt <= BKND_WAIT + REINIT_LEN + 2)
    else $error("fault recovery too long");
  a_fault_outputs: assert property (fault_active_o |-> !valid_o && sda_oe_n_o && pwm_p_o[3:0] == 0 &&
    pwm_m_o[3:0] == 0 && pwm_p_o[7:6] == 0 && pwm_m_o[7:6] == 0 && headphone_pwm_p_o == 0 && headphone_pwm_m_o == 0)
    else $error("outputs active during fault");
  a_mute_no_rise: assert property ((power_down_n_i && !mute_n_i)[*6] |-> volume_o <= $past(volume_o))
    else $error("volume rose while muted");
  a_mute_silent: assert property ((power_down_n_i && !mute_n_i)[*6] |-> ##[0:270] volume_o == 0)
    else $error("mute did not reach silence");
  a_hp_select: assert property ((power_down_n_i && !headphone_speaker_select_i && $stable(headphone_config_i))[*6]
    |-> ch12_config_o == headphone_config_i && pwm_p_o[1:0] == 0 && pwm_m_o[1:0] == 0)
    else $error("headphone selection not applied");
  a_spk_select: assert property ((power_down_n_i && headphone_speaker_select_i)[*6]
    |-> ch12_config_o == 8'h00 && headphone_pwm_p_o == 0 && headphone_pwm_m_o == 0)
    else $error("speaker selection not applied");
  a_select_mutes: assert property ($changed(headphone_speaker_select_i) && power_down_n_i |-> ##[1:270] volume_o == 0)
    else $error("select change without mute");
endmodule // audio_pin_seq_checker
bind audio_pin_control_sequencer audio_pin_seq_checker #(.NUM_CH(NUM_CH), .BKND_WAIT(BKND_WAIT),
  .REINIT_LEN(REINIT_LEN), .RATE_DET_LEN(RATE_DET_LEN)) i_audio_pin_seq_checker (.clk_i, .resetn_i,
  .power_down_n_i, .backend_fault_n_i, .headphone_speaker_select_i, .mute_n_i, .headphone_config_i,
  .serial_audio_accept_o, .pll_enable_o, .osc_enable_o, .valid_o, .pwm_p_o, .pwm_m_o, .headphone_pwm_p_o,
  .headphone_pwm_m_o, .supply_volume_ctrl_out_o, .sda_oe_n_o, .volume_o, .ch12_config_o, .fault_active_o);

// [audio_pin_seq_defs.vh]
// audio_pin_seq_defs.vh: constants for the pin-driven operating-state sequencer
// assumes: included by audio_pin_control_sequencer.v, clock at 125 MHz
`ifndef AUDIO_PIN_SEQ_DEFS_VH
`define AUDIO_PIN_SEQ_DEFS_VH

// register offsets (8-bit register address)
`define REG_LINEOUT_CH5_CONFIG   8'h09
`define REG_LINEOUT_CH6_CONFIG   8'h0a
`define REG_OUTPUT_MIXER_CONFIG  8'hd0
`define REG_GENERAL_CONTROL      8'he0
// reset values
`define RST_LINEOUT_CONFIG       8'he0
`define RST_OUTPUT_MIXER_CONFIG  32'h00000000
`define RST_GENERAL_CONTROL      32'h00000000
// field positions
`define GC_CHANNEL_COUNT_BIT     1
`define GC_SUPPLY_VOLUME_CTRL_OUT_ENABLE_BIT       2
`define GC_MASTER_MUTE_N_BIT     0
`define OMC_MIXER_SELECT_BIT     30
// timing
`define BKND_LOW_MIN_CYCLES      5
`define BKND_WAIT_MS             5
`define CLK_MHZ                  125
`define BKND_WAIT_CYCLES         (`BKND_WAIT_MS * 1000 * `CLK_MHZ)
`define REINIT_CYCLES            64
`define RATE_DETECT_CYCLES       256
`define RAMP_STEPS               255

`endif

// [power_stage_model.sv]
// power_stage_model.sv: far-side power stage, raises back-end faults and feeds modulator bits
// assumes: shares the sequencer clock, fault requests come from the bench
`timescale 1ns/10ps
module power_stage_model (
  input  wire       clk_i,
  input  wire       fault_go_i,
  input  wire [7:0] fault_len_i,
  output reg        backend_fault_n_o,
  output reg  [7:0] pwm_data_o
);
  reg [7:0] left;
  initial begin
    backend_fault_n_o = 1'b1;
    pwm_data_o = 8'h5a;
    left = 8'h00;
  end
  always @(posedge clk_i) begin
    pwm_data_o <= ~pwm_data_o;
    if (fault_go_i) left <= fault_len_i;
    else if (left != 0) left <= left - 8'h01;
    // fault level held low for exactly fault_len_i cycles
    backend_fault_n_o <= !(fault_go_i || left > 8'h01);
  end
endmodule // power_stage_model
